// ---- core/ikl_pkg.sv ----
package ikl_pkg;

    // key/status register location in the special-function space
    localparam logic [7:0] KEY_STATUS_ADDR = 8'hae;
    localparam logic [7:0] KEY_STATUS_RESET = 8'h00;

    // key values written in order to unlock
    localparam logic [7:0] FIRST_KEY = 8'ha5;
    localparam logic [7:0] SECOND_KEY = 8'hf1;

    // state codes returned on read
    localparam logic [7:0] CODE_LOCKED = 8'h00;
    localparam logic [7:0] CODE_WAITING = 8'h01;
    localparam logic [7:0] CODE_UNLOCKED = 8'h02;
    localparam logic [7:0] CODE_DISABLED = 8'h03;

    // value driven on a read of any other address
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    typedef enum logic [3:0] {
        ST_LOCKED = 4'b0001,
        ST_WAITING = 4'b0010,
        ST_UNLOCKED = 4'b0100,
        ST_DISABLED = 4'b1000
    } ikl_state_e;

    // address decode shared by read and write paths
    function automatic logic ikl_addr_hit(input logic [7:0] addr);
        return addr == KEY_STATUS_ADDR;
    endfunction

    // state to read-back code
    function automatic logic [7:0] ikl_state_code(input ikl_state_e st);
        case (st)
            ST_LOCKED: return CODE_LOCKED;
            ST_WAITING: return CODE_WAITING;
            ST_UNLOCKED: return CODE_UNLOCKED;
            ST_DISABLED: return CODE_DISABLED;
            default: return CODE_LOCKED;
        endcase
    endfunction

endpackage

// ---- core/ikl_key_if.sv ----
`timescale 1ns/1ps
interface ikl_key_if;
    logic wr_stb;
    logic [7:0] wr_data;
    ikl_pkg::ikl_state_e state;

    // decoder side: issues key writes, watches state
    modport decoder (
        output wr_stb,
        output wr_data,
        input state
    );

    // state machine side
    modport fsm (
        input wr_stb,
        input wr_data,
        output state
    );
endinterface

// ---- core/ikl_key_fsm.sv ----
`timescale 1ns/1ps
module ikl_key_fsm (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    ikl_key_if.fsm key // key writes in, state out
);

    ikl_pkg::ikl_state_e state_q;
    ikl_pkg::ikl_state_e state_d;

    // next state from a decoded key write
    always_comb begin
        state_d = state_q;
        if (key.wr_stb) begin
            case (state_q)
                ikl_pkg::ST_LOCKED: begin
                    if (key.wr_data == ikl_pkg::FIRST_KEY) begin
                        state_d = ikl_pkg::ST_WAITING;
                    end else begin
                        state_d = ikl_pkg::ST_LOCKED;
                    end
                end
                ikl_pkg::ST_WAITING: begin
                    if (key.wr_data == ikl_pkg::SECOND_KEY) begin
                        state_d = ikl_pkg::ST_UNLOCKED;
                    end else begin
                        state_d = ikl_pkg::ST_DISABLED;
                    end
                end
                ikl_pkg::ST_UNLOCKED: begin
                    state_d = ikl_pkg::ST_LOCKED;
                end
                ikl_pkg::ST_DISABLED: begin
                    state_d = ikl_pkg::ST_DISABLED;
                end
                default: begin
                    state_d = ikl_pkg::ST_LOCKED;
                end
            endcase
        end
    end

    // state register, locked after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ikl_pkg::ST_LOCKED;
        end else begin
            state_q <= state_d;
        end
    end

    assign key.state = state_q;

endmodule // ikl_key_fsm

// ---- core/ikl_key_lock.sv ----
`timescale 1ns/1ps
// Contract
// - a read of the key/status register returns 0x00 locked, 0x01 waiting, 0x02 unlocked, 0x03 disabled.
// - from locked, writing the first key then the second key moves through waiting to unlocked.
// - in waiting, writing anything but the second key moves to disabled until the next reset.
// - in unlocked, any write to the register returns to locked.
// - in disabled, every write is ignored and only a reset restores locked.
module ikl_key_lock (
    input wire logic clk, // system clock, 10 MHz
    input wire logic rstn, // async reset, active low
    input wire logic [7:0] sfr_addr, // special-function address
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic sfr_wr, // write strobe, one cycle
    input wire logic sfr_rd, // read strobe, one cycle
    output logic [7:0] sfr_rdata_q, // read data, one cycle after sfr_rd
    output logic access_ok_q // clock interface access permitted
);

    ikl_key_if u_key_if();

    logic wr_hit;
    logic rd_hit;
    logic [7:0] code;

    // address decode
    assign wr_hit = sfr_wr && ikl_pkg::ikl_addr_hit(sfr_addr);
    assign rd_hit = sfr_rd && ikl_pkg::ikl_addr_hit(sfr_addr);

    // key writes handed to the state machine
    assign u_key_if.wr_stb = wr_hit;
    assign u_key_if.wr_data = sfr_wdata;

    // current read-back code
    assign code = ikl_pkg::ikl_state_code(u_key_if.state);

    ikl_key_fsm u_fsm (
        .clk(clk),
        .rstn(rstn),
        .key(u_key_if.fsm)
    );

    // read data register, shows the state before any same-cycle write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata_q <= ikl_pkg::KEY_STATUS_RESET;
        end else if (rd_hit) begin
            sfr_rdata_q <= code;
        end else begin
            sfr_rdata_q <= ikl_pkg::UNMAPPED_READ;
        end
    end

    // access-permitted flag, follows the unlocked state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            access_ok_q <= 1'b0;
        end else begin
            access_ok_q <= (u_key_if.state == ikl_pkg::ST_UNLOCKED);
        end
    end

    // read returns the code of the state at the read
    property p_read_code;
        @(posedge clk) disable iff (!rstn)
        rd_hit |=> sfr_rdata_q == $past(code);
    endproperty
    a_read_code: assert property (p_read_code)
        else $error("read data does not match state code");

    // code always one of the four values
    property p_code_range;
        @(posedge clk) disable iff (!rstn)
        code <= ikl_pkg::CODE_DISABLED;
    endproperty
    a_code_range: assert property (p_code_range)
        else $error("state code out of range");

    // two ordered keys from locked reach unlocked
    property p_unlock_seq;
        @(posedge clk) disable iff (!rstn)
        (code == ikl_pkg::CODE_LOCKED && wr_hit && sfr_wdata == ikl_pkg::FIRST_KEY)
        ##1 (wr_hit && sfr_wdata == ikl_pkg::SECOND_KEY)
        |=> code == ikl_pkg::CODE_UNLOCKED;
    endproperty
    a_unlock_seq: assert property (p_unlock_seq)
        else $error("key sequence did not unlock");

    // first key from locked moves to waiting
    property p_first_key;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_LOCKED && wr_hit && sfr_wdata == ikl_pkg::FIRST_KEY
        |=> code == ikl_pkg::CODE_WAITING;
    endproperty
    a_first_key: assert property (p_first_key)
        else $error("first key not accepted");

    // wrong second key disables
    property p_wrong_key;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_WAITING && wr_hit && sfr_wdata != ikl_pkg::SECOND_KEY
        |=> code == ikl_pkg::CODE_DISABLED;
    endproperty
    a_wrong_key: assert property (p_wrong_key)
        else $error("wrong second key did not disable");

    // any write while unlocked relocks
    property p_relock;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_UNLOCKED && wr_hit |=> code == ikl_pkg::CODE_LOCKED;
    endproperty
    a_relock: assert property (p_relock)
        else $error("write while unlocked did not lock");

    // disabled is sticky for several cycles whatever is written
    property p_disabled_sticky;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_DISABLED |=> (code == ikl_pkg::CODE_DISABLED) [*4];
    endproperty
    a_disabled_sticky: assert property (p_disabled_sticky)
        else $error("disabled state left without reset");

    // access flag tracks unlocked state one cycle later
    property p_access;
        @(posedge clk) disable iff (!rstn)
        ##1 access_ok_q == $past(code == ikl_pkg::CODE_UNLOCKED);
    endproperty
    a_access: assert property (p_access)
        else $error("access flag disagrees with unlocked state");

    // non-key write in locked leaves it locked
    property p_locked_other;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_LOCKED && wr_hit && sfr_wdata != ikl_pkg::FIRST_KEY
        |=> code == ikl_pkg::CODE_LOCKED;
    endproperty
    a_locked_other: assert property (p_locked_other)
        else $error("locked state changed by non-key write");

    // without a write to the register the state holds
    property p_no_write_stable;
        @(posedge clk) disable iff (!rstn)
        !wr_hit |=> $stable(code);
    endproperty
    a_no_write_stable: assert property (p_no_write_stable)
        else $error("state changed without a register write");

    // unmapped or idle reads return zero
    property p_unmapped_read;
        @(posedge clk) disable iff (!rstn)
        !rd_hit |=> sfr_rdata_q == ikl_pkg::UNMAPPED_READ;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("read data not zero without a register read");

    // second key in waiting unlocks
    property p_second_key;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_WAITING && wr_hit && sfr_wdata == ikl_pkg::SECOND_KEY
        |=> code == ikl_pkg::CODE_UNLOCKED;
    endproperty
    a_second_key: assert property (p_second_key)
        else $error("second key did not unlock");

    // a write while disabled changes nothing
    property p_disabled_write;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_DISABLED && wr_hit |=> code == ikl_pkg::CODE_DISABLED;
    endproperty
    a_disabled_write: assert property (p_disabled_write)
        else $error("write while disabled changed the state");

    // no access flag unless the state was unlocked
    property p_no_access;
        @(posedge clk) disable iff (!rstn)
        code != ikl_pkg::CODE_UNLOCKED |=> !access_ok_q;
    endproperty
    a_no_access: assert property (p_no_access)
        else $error("access flag high outside unlocked state");

    // access flag rises only after the second key from waiting
    property p_access_rise;
        @(posedge clk) disable iff (!rstn)
        $rose(access_ok_q) |-> $past(code, 2) == ikl_pkg::CODE_WAITING;
    endproperty
    a_access_rise: assert property (p_access_rise)
        else $error("access flag rose without the key sequence");

    // access flag falls only after a relocking write
    property p_access_fall;
        @(posedge clk) disable iff (!rstn)
        $fell(access_ok_q) |-> $past(wr_hit, 2);
    endproperty
    a_access_fall: assert property (p_access_fall)
        else $error("access flag fell without a register write");

    // state register always holds one legal one-hot code
    property p_state_onehot;
        @(posedge clk) disable iff (!rstn)
        $onehot(u_key_if.state);
    endproperty
    a_state_onehot: assert property (p_state_onehot)
        else $error("state register holds an illegal code");

    // main scenarios
    property p_cov_unlock;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_WAITING ##1 code == ikl_pkg::CODE_UNLOCKED;
    endproperty
    c_cov_unlock: cover property (p_cov_unlock);

    property p_cov_disable;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_WAITING ##1 code == ikl_pkg::CODE_DISABLED;
    endproperty
    c_cov_disable: cover property (p_cov_disable);

    property p_cov_relock;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_UNLOCKED ##1 code == ikl_pkg::CODE_LOCKED;
    endproperty
    c_cov_relock: cover property (p_cov_relock);

    property p_cov_disabled_write;
        @(posedge clk) disable iff (!rstn)
        code == ikl_pkg::CODE_DISABLED && wr_hit ##1 code == ikl_pkg::CODE_DISABLED;
    endproperty
    c_cov_disabled_write: cover property (p_cov_disabled_write);

endmodule // ikl_key_lock

// ---- testbench/ikl_key_lock_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
    compares += 1; \
    if ((gt) !== (ex)) begin \
        n_mismatch += 1; \
        $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
    end
module ikl_key_lock_tb_top;
    logic clk;
    logic rstn;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_rdata_q;
    logic access_ok_q;
    int n_mismatch;
    int compares;
    localparam logic [7:0] KA = ikl_pkg::KEY_STATUS_ADDR;

    // device under test
    ikl_key_lock u_ikl_key_lock (
        .clk(clk),
        .rstn(rstn),
        .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_rdata_q(sfr_rdata_q),
        .access_ok_q(access_ok_q)
    );

    // 10 MHz system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // one bus cycle: strobes stand for exactly one edge, next call replaces them
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        sfr_wr = w;
        sfr_rd = r;
        sfr_addr = a;
        sfr_wdata = d;
        @(posedge clk);
        #1;
    endtask

    // read the key/status register, compare code and access flag
    task automatic rd_code(input logic [7:0] exp, input logic exp_ok);
        acc(1'b0, 1'b1, KA, 8'h00);
        `CHK("state code", exp, sfr_rdata_q)
        `CHK("access flag", exp_ok, access_ok_q)
    endtask

    // mid-run reset pulse
    task automatic pulse_reset();
        acc(1'b0, 1'b0, KA, 8'h00);
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
    endtask

    // verdict and end of run
    task automatic results();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung run
    initial begin
        #1000000;
        n_mismatch += 1;
        results();
    end

    // main sequence
    initial begin
        n_mismatch = 0;
        compares = 0;
        rstn = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        rd_code(ikl_pkg::CODE_LOCKED, 1'b0);
        acc(1'b0, 1'b0, KA, 8'h00);
        `CHK("idle read data", 8'h00, sfr_rdata_q)
        // locked: non-key writes change nothing, unmapped read gives zero
        acc(1'b1, 1'b0, KA, ikl_pkg::SECOND_KEY);
        acc(1'b1, 1'b0, KA, 8'h00);
        rd_code(ikl_pkg::CODE_LOCKED, 1'b0);
        acc(1'b0, 1'b1, 8'h10, 8'h00);
        `CHK("unmapped read", 8'h00, sfr_rdata_q)
        // read and first key in the same cycle: old code returned
        acc(1'b1, 1'b1, KA, ikl_pkg::FIRST_KEY);
        `CHK("read with write", ikl_pkg::CODE_LOCKED, sfr_rdata_q)
        rd_code(ikl_pkg::CODE_WAITING, 1'b0);
        acc(1'b1, 1'b0, KA, ikl_pkg::SECOND_KEY);
        rd_code(ikl_pkg::CODE_UNLOCKED, 1'b1);
        // any write while unlocked locks, even the first key
        acc(1'b1, 1'b0, KA, ikl_pkg::FIRST_KEY);
        rd_code(ikl_pkg::CODE_LOCKED, 1'b0);
        // back-to-back keys with strobe held
        acc(1'b1, 1'b0, KA, ikl_pkg::FIRST_KEY);
        acc(1'b1, 1'b0, KA, ikl_pkg::SECOND_KEY);
        rd_code(ikl_pkg::CODE_UNLOCKED, 1'b1);
        acc(1'b1, 1'b0, KA, 8'h55);
        rd_code(ikl_pkg::CODE_LOCKED, 1'b0);
        // wrong second key, other-address write in between ignored
        acc(1'b1, 1'b0, KA, ikl_pkg::FIRST_KEY);
        acc(1'b1, 1'b0, 8'h10, ikl_pkg::SECOND_KEY);
        rd_code(ikl_pkg::CODE_WAITING, 1'b0);
        acc(1'b1, 1'b0, KA, 8'h00);
        rd_code(ikl_pkg::CODE_DISABLED, 1'b0);
        // disabled ignores keys until reset
        acc(1'b1, 1'b0, KA, ikl_pkg::FIRST_KEY);
        acc(1'b1, 1'b0, KA, ikl_pkg::SECOND_KEY);
        rd_code(ikl_pkg::CODE_DISABLED, 1'b0);
        pulse_reset();
        rd_code(ikl_pkg::CODE_LOCKED, 1'b0);
        acc(1'b1, 1'b0, KA, ikl_pkg::FIRST_KEY);
        acc(1'b1, 1'b0, KA, ikl_pkg::SECOND_KEY);
        rd_code(ikl_pkg::CODE_UNLOCKED, 1'b1);
        // waiting state also disabled by a repeated first key
        acc(1'b1, 1'b0, KA, 8'h01);
        acc(1'b1, 1'b0, KA, ikl_pkg::FIRST_KEY);
        acc(1'b1, 1'b0, KA, ikl_pkg::FIRST_KEY);
        rd_code(ikl_pkg::CODE_DISABLED, 1'b0);
        acc(1'b0, 1'b0, KA, 8'h00);
        results();
    end
endmodule // ikl_key_lock_tb_top
